// >>> ifau_map.svh
`ifndef IFAU_MAP_SVH
`define IFAU_MAP_SVH
`define IFAU_ADDR_W 24
`define IFAU_OCTET_W 21
`define IFAU_CNT_W 12
`define IFAU_WORD_W 32
`define IFAU_LVL_W 3
`define IFAU_OCTET_STEP 24'h000008
`define IFAU_WORD_STEP 24'h000001
`define IFAU_LAST_WORD 3'h7
`define IFAU_ADDR_RST 24'h000000
`define IFAU_CNT_RST 12'h000
`endif

// >>> ifau_pkg.sv
`include "ifau_map.svh"
package ifau_pkg;
	typedef logic [`IFAU_ADDR_W-1:0] ifau_addr_t;
	typedef logic [`IFAU_CNT_W-1:0] ifau_cnt_t;
	typedef logic [`IFAU_WORD_W-1:0] ifau_word_t;
	typedef enum logic [1:0] {
		IFAU_IDLE = 2'h0,
		IFAU_REQ = 2'h1,
		IFAU_WAIT = 2'h3
	} ifau_fetch_e;
	typedef struct packed {
		logic start;
		logic hazard;
		logic branch;
		logic obj_in_octet;
		logic load_lookahead_instruction;
		ifau_addr_t stage3_program_address;
		ifau_addr_t adder_result;
		ifau_cnt_t displacement;
		logic [`IFAU_LVL_W-1:0] active_levels;
		logic stop;
	} ifau_stage3_s;
	typedef struct packed {
		logic mem_req;
		logic [`IFAU_OCTET_W-1:0] mem_octet_addr;
	} ifau_memreq_s;
	typedef struct packed {
		ifau_fetch_e fsm;
		ifau_addr_t fetch_ahead_pointer;
		ifau_addr_t present_word_pointer;
		ifau_addr_t memory_request_pointer;
		ifau_addr_t branch_return;
		ifau_addr_t stage1_program_address;
		ifau_cnt_t lla_count;
		logic lla_armed;
		logic file_sel;
		logic file_sel_pend;
		logic fill_sel;
		logic [1:0] file_full;
		ifau_word_t instruction_holding_register;
	} ifau_state_s;
endpackage

// >>> ifau_fetch_unit.sv
`timescale 1ns/10ps
`include "ifau_map.svh"
module ifau_fetch_unit import ifau_pkg::*; (
	input wire logic clock, // 10 MHz system clock
	input wire logic rst, // synchronous, active high
	input wire ifau_stage3_s s3, // stage-3 redirect and look-ahead inputs
	output ifau_memreq_s mreq, // octet request toward memory
	input wire logic mem_accept, // memory takes the request this cycle
	input wire logic mem_data_valid, // octet returned from memory
	input wire logic [8*`IFAU_WORD_W-1:0] memory_interface_file, // returned octet
	input wire logic ir_take, // stage 1 accepts an instruction word
	output logic word_valid, // selected file holds a valid octet
	output ifau_word_t instruction_holding_register, // word entered this cycle
	output ifau_addr_t stage1_program_address, // address travelling with it
	output ifau_addr_t fetch_ahead_pointer, // feeds far-hazard comparator
	output ifau_addr_t compare_octet, // feeds branch/execute/indirect comparator
	output logic file_sel, // active instruction file, 0 is a
	output logic [1:0] file_full // full flags of files a and b
);
	ifau_state_s q_reg, q_next;
	ifau_word_t instruction_file_a [8];
	ifau_word_t instruction_file_b [8];
	logic redirect, lla_fire, last_word;
	ifau_addr_t octet_sum;

	assign octet_sum = q_reg.fetch_ahead_pointer + `IFAU_OCTET_STEP;
	assign last_word = q_reg.present_word_pointer[2:0] == `IFAU_LAST_WORD;
	// the active-level count is taken off at load time, so the counter itself hits zero
	assign lla_fire = q_reg.lla_armed && q_reg.lla_count == `IFAU_CNT_RST;
	assign redirect = s3.hazard || s3.start || (s3.branch && !s3.obj_in_octet);

	// the idle file is filled; the file being drawn from is never overwritten
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_files
			always_ff @(posedge clock) begin
				if (rst) begin
					instruction_file_a[gi] <= '0;
					instruction_file_b[gi] <= '0;
				end else if (mem_data_valid) begin
					if (!q_reg.fill_sel)
						instruction_file_a[gi] <= memory_interface_file[gi*32 +: 32];
					else
						instruction_file_b[gi] <= memory_interface_file[gi*32 +: 32];
				end
			end
		end
	endgenerate

	always_comb begin
		q_next = q_reg;
		// hazard, then start, then branch, then look-ahead transfer, then sequential
		if (s3.hazard) begin
			q_next.fetch_ahead_pointer = s3.stage3_program_address;
			q_next.memory_request_pointer = s3.stage3_program_address;
			q_next.present_word_pointer = s3.stage3_program_address;
			q_next.fsm = IFAU_REQ;
		end else if (s3.start) begin
			q_next.fetch_ahead_pointer = s3.stage3_program_address;
			q_next.memory_request_pointer = s3.stage3_program_address;
			q_next.present_word_pointer = s3.stage3_program_address;
			q_next.fsm = IFAU_REQ;
		end else if (s3.branch && !s3.obj_in_octet) begin
			q_next.fetch_ahead_pointer = s3.adder_result;
			q_next.memory_request_pointer = s3.adder_result;
			q_next.present_word_pointer = s3.adder_result;
			q_next.fsm = IFAU_REQ;
		end else if (lla_fire) begin
			q_next.fetch_ahead_pointer = q_reg.branch_return;
			q_next.memory_request_pointer = q_reg.branch_return;
			// words resume from the saved path once its octet lands
			q_next.present_word_pointer = q_reg.branch_return;
			q_next.lla_armed = 1'b0;
			q_next.fsm = IFAU_REQ;
		end else begin
			if (mreq.mem_req && mem_accept) begin
				q_next.fetch_ahead_pointer = octet_sum;
				q_next.memory_request_pointer = octet_sum;
			end
			if (s3.branch && s3.obj_in_octet)
				q_next.present_word_pointer = s3.adder_result;
			else if (ir_take && word_valid) begin
				// the fetch-ahead pointer may already run an octet past the next file,
				// so the next octet base is formed from the present pointer itself
				if (last_word)
					q_next.present_word_pointer =
						{q_reg.present_word_pointer[23:3] + 21'h000001, 3'h0};
				else
					q_next.present_word_pointer =
						q_reg.present_word_pointer + `IFAU_WORD_STEP;
			end
		end
		// request sequencing: stop ends the sequence unless a redirect or a look-ahead transfer restarts it
		case (q_reg.fsm)
			IFAU_IDLE: ;
			IFAU_REQ: begin
				if (!redirect && !lla_fire && s3.stop)
					q_next.fsm = IFAU_IDLE;
				else if (!redirect && !lla_fire && mreq.mem_req && mem_accept)
					q_next.fsm = IFAU_WAIT;
			end
			IFAU_WAIT: begin
				if (!redirect && !lla_fire && mem_data_valid)
					q_next.fsm = s3.stop ? IFAU_IDLE : IFAU_REQ;
			end
			default: q_next.fsm = IFAU_IDLE;
		endcase
		if (mem_data_valid) begin
			q_next.file_full[q_reg.fill_sel] = 1'b1;
			q_next.fill_sel = ~q_reg.fill_sel;
		end
		if (s3.load_lookahead_instruction) begin
			q_next.branch_return = s3.stage3_program_address;
			// limitation: a displacement below the active-level count wraps around
			q_next.lla_count = s3.displacement - ifau_cnt_t'(s3.active_levels);
			q_next.lla_armed = 1'b1;
		end else if (q_reg.lla_armed && ir_take && word_valid && !lla_fire)
			q_next.lla_count = q_reg.lla_count - 12'h001;
		q_next.file_sel_pend = 1'b0;
		if (ir_take && word_valid) begin
			q_next.stage1_program_address = q_reg.present_word_pointer;
			q_next.instruction_holding_register = q_reg.file_sel ?
				instruction_file_b[q_reg.present_word_pointer[2:0]] :
				instruction_file_a[q_reg.present_word_pointer[2:0]];
			q_next.file_sel_pend = last_word;
		end
		// toggle lands one clock after the last word is drawn
		if (q_reg.file_sel_pend) begin
			q_next.file_full[q_reg.file_sel] = 1'b0;
			q_next.file_sel = ~q_reg.file_sel;
		end
		if (redirect || lla_fire) begin
			// stale octets are dropped; the new one lands in file a
			q_next.file_full = 2'b00;
			q_next.file_sel = 1'b0;
			q_next.fill_sel = 1'b0;
			q_next.file_sel_pend = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q_reg <= '{fsm: IFAU_IDLE, fetch_ahead_pointer: `IFAU_ADDR_RST,
				present_word_pointer: `IFAU_ADDR_RST, memory_request_pointer: `IFAU_ADDR_RST,
				branch_return: `IFAU_ADDR_RST, stage1_program_address: `IFAU_ADDR_RST,
				lla_count: `IFAU_CNT_RST, lla_armed: 1'b0, file_sel: 1'b0,
				file_sel_pend: 1'b0, fill_sel: 1'b0, file_full: 2'b00,
				instruction_holding_register: '0};
		end else begin
			q_reg <= q_next;
		end
	end

	// a request waits while the file it would fill still holds unread words
	assign mreq.mem_req = q_reg.fsm == IFAU_REQ && !q_reg.file_full[q_reg.fill_sel];
	assign mreq.mem_octet_addr = q_reg.memory_request_pointer[`IFAU_ADDR_W-1:3];
	assign word_valid = q_reg.file_full[q_reg.file_sel] && !q_reg.file_sel_pend;
	assign instruction_holding_register = q_reg.instruction_holding_register;
	assign stage1_program_address = q_reg.stage1_program_address;
	assign fetch_ahead_pointer = q_reg.fetch_ahead_pointer;
	assign compare_octet = {q_reg.fetch_ahead_pointer[`IFAU_ADDR_W-1:3], 3'h0};
	assign file_sel = q_reg.file_sel;
	assign file_full = q_reg.file_full;

	a_accept_step: assert property (@(posedge clock) disable iff (rst)
		mreq.mem_req && mem_accept && !redirect && !lla_fire
		|=> fetch_ahead_pointer == $past(fetch_ahead_pointer) + `IFAU_OCTET_STEP)
		else $error("octet step missing after accept");
	a_start_load: assert property (@(posedge clock) disable iff (rst)
		s3.start && !s3.hazard |=> q_reg.present_word_pointer == $past(s3.stage3_program_address)
		&& mreq.mem_req)
		else $error("start did not load pointers");
	a_branch_load: assert property (@(posedge clock) disable iff (rst)
		s3.branch && !s3.obj_in_octet && !s3.hazard && !s3.start
		|=> fetch_ahead_pointer == $past(s3.adder_result))
		else $error("branch target not loaded");
	a_hazard_first: assert property (@(posedge clock) disable iff (rst)
		s3.hazard |=> q_reg.memory_request_pointer == $past(s3.stage3_program_address))
		else $error("hazard refetch lost priority");
	a_lla_save: assert property (@(posedge clock) disable iff (rst)
		s3.load_lookahead_instruction |=> q_reg.branch_return == $past(s3.stage3_program_address)
		&& q_reg.lla_count == $past(s3.displacement) - ifau_cnt_t'($past(s3.active_levels)))
		else $error("look-ahead save failed");
	a_pa_incr: assert property (@(posedge clock) disable iff (rst)
		ir_take && word_valid && !last_word && !redirect && !lla_fire && !s3.branch
		|=> q_reg.present_word_pointer == $past(q_reg.present_word_pointer) + 24'h000001)
		else $error("present pointer did not step");
	a_p1_copy: assert property (@(posedge clock) disable iff (rst)
		ir_take && word_valid |=> stage1_program_address == $past(q_reg.present_word_pointer))
		else $error("stage-1 address not copied");
	sequence s_last_taken;
		ir_take && word_valid && last_word && !redirect && !lla_fire;
	endsequence
	a_file_toggle: assert property (@(posedge clock) disable iff (rst)
		s_last_taken ##1 !redirect && !lla_fire |=> file_sel != $past(file_sel, 2))
		else $error("file select did not toggle");
	a_octet_addr: assert property (@(posedge clock) disable iff (rst)
		mreq.mem_req |-> mreq.mem_octet_addr == fetch_ahead_pointer[23:3])
		else $error("octet address mismatch");
	a_lla_fire: assert property (@(posedge clock) disable iff (rst)
		lla_fire && !redirect
		|=> mreq.mem_req && mreq.mem_octet_addr == $past(q_reg.branch_return[23:3]))
		else $error("look-ahead transfer missing");
	a_lla_dec: assert property (@(posedge clock) disable iff (rst)
		q_reg.lla_armed && ir_take && word_valid && !s3.load_lookahead_instruction && !lla_fire
		|=> q_reg.lla_count == $past(q_reg.lla_count) - 12'h001)
		else $error("look-ahead count did not step");
	a_inoct_load: assert property (@(posedge clock) disable iff (rst)
		s3.branch && s3.obj_in_octet && !s3.hazard && !s3.start && !lla_fire
		|=> q_reg.present_word_pointer == $past(s3.adder_result))
		else $error("in-octet object not loaded");
	a_last_wrap: assert property (@(posedge clock) disable iff (rst)
		s_last_taken && !(s3.branch && s3.obj_in_octet)
		|=> q_reg.present_word_pointer[2:0] == 3'h0)
		else $error("present pointer did not reach next octet");
	a_fill_idle: assert property (@(posedge clock) disable iff (rst)
		mem_data_valid && !redirect && !lla_fire |-> !q_reg.file_full[q_reg.fill_sel])
		else $error("octet written into a full file");
endmodule

// >>> ifau_mem_model.sv
`timescale 1ns/10ps
`include "ifau_map.svh"
module ifau_mem_model import ifau_pkg::*; (
	input wire logic clock, // system clock
	input wire logic rst, // sync reset
	input wire ifau_memreq_s mreq, // octet request
	input wire logic hold, // stall: nothing accepted while high
	output logic mem_accept, // request taken
	output logic mem_data_valid, // octet on bus
	output logic [8*`IFAU_WORD_W-1:0] memory_interface_file, // octet data
	output logic busy // transfer in flight
);
	logic pend;
	logic cnt;
	logic [`IFAU_OCTET_W-1:0] oa;
	logic [8*`IFAU_WORD_W-1:0] oct;
	// each word holds its own address so the bench can predict it
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			oct[32*i+:32] = {8'h00, oa, 3'(i)};
		end
	end
	// bus is not held after the valid cycle, so a late sampler sees junk
	assign memory_interface_file = mem_data_valid ? oct : ~oct;
	assign busy = pend | mem_accept;
	always @(posedge clock) begin
		mem_accept <= 1'h0;
		mem_data_valid <= 1'h0;
		if (rst) begin
			pend <= 1'h0;
			cnt <= 1'h1;
			oa <= 21'h0;
		end else if (mem_accept) begin
			pend <= mreq.mem_req;
			oa <= mreq.mem_octet_addr;
			cnt <= 1'h1;
		end else if (pend) begin
			cnt <= 1'h0;
			pend <= cnt;
			mem_data_valid <= ~cnt;
		end else if (mreq.mem_req && !hold) begin
			cnt <= 1'h0;
			mem_accept <= ~cnt;
		end else begin
			cnt <= 1'h1;
		end
	end
endmodule

// >>> instruction_fetch_address_unit_test.sv
`timescale 1ns/10ps
`include "ifau_map.svh"
module instruction_fetch_address_unit_test import ifau_pkg::*;;
	logic clock, rst, ir_take, hold, mem_accept, mem_data_valid, busy, word_valid, file_sel;
	ifau_stage3_s s3, r;
	ifau_memreq_s mreq;
	logic [8*`IFAU_WORD_W-1:0] mif;
	ifau_word_t ihr;
	ifau_addr_t s1a, fap;
	logic [1:0] file_full;
	int miscompares = 0;
	int tests_run = 0;
	ifau_fetch_unit u_ifau_fetch_unit (.clock(clock), .rst(rst), .s3(s3), .mreq(mreq),
		.mem_accept(mem_accept), .mem_data_valid(mem_data_valid),
		.memory_interface_file(mif), .ir_take(ir_take), .word_valid(word_valid),
		.instruction_holding_register(ihr), .stage1_program_address(s1a),
		.fetch_ahead_pointer(fap), .compare_octet(), .file_sel(file_sel), .file_full(file_full));
	ifau_mem_model u_ifau_mem_model (.clock(clock), .rst(rst), .mreq(mreq), .hold(hold),
		.mem_accept(mem_accept), .mem_data_valid(mem_data_valid),
		.memory_interface_file(mif), .busy(busy));
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_up;
		chk(32'h0, 32'h1);
		print_verdict;
	endtask
	// memory is stalled around a redirect so no stale octet races the new one
	task automatic redirect(input logic chkreq, input ifau_addr_t a);
		hold = 1'h1;
		for (int n = 0; n < 20 && busy; n++) @(negedge clock);
		if (busy) give_up;
		s3 = r;
		@(negedge clock);
		s3 = '0;
		@(negedge clock);
		if (chkreq) begin
			chk(mreq.mem_req, 1'h1);
			chk(mreq.mem_octet_addr, a[23:3]);
		end
		hold = 1'h0;
		r = '0;
	endtask
	task automatic take(input ifau_addr_t a);
		for (int n = 0; n < 60 && word_valid !== 1'h1; n++) @(negedge clock);
		if (word_valid !== 1'h1) give_up;
		ir_take = 1'h1;
		@(negedge clock);
		ir_take = 1'h0;
		chk(ihr, {8'h00, a});
		chk(s1a, a);
	endtask
	task automatic t_start;
		r.start = 1'h1;
		r.stage3_program_address = 24'h000105;
		redirect(1'h1, 24'h000105);
		chk(fap, 24'h000105);
		take(24'h000105);
		take(24'h000106);
		take(24'h000107);
		take(24'h000108);
		chk(file_sel, 1'h1);
		take(24'h000109);
		$display("start sequence done");
	endtask
	task automatic t_branch;
		r.branch = 1'h1;
		r.adder_result = 24'h000233;
		redirect(1'h1, 24'h000233);
		take(24'h000233);
		take(24'h000234);
		$display("branch done");
	endtask
	task automatic t_hazard;
		r.hazard = 1'h1;
		r.branch = 1'h1;
		r.stage3_program_address = 24'h000340;
		r.adder_result = 24'h000500;
		redirect(1'h1, 24'h000340);
		take(24'h000340);
		$display("hazard done");
	endtask
	task automatic t_inoct;
		r.branch = 1'h1;
		r.obj_in_octet = 1'h1;
		r.adder_result = 24'h000346;
		redirect(1'h0, 24'h0);
		take(24'h000346);
		take(24'h000347);
		$display("in-octet branch done");
	endtask
	task automatic t_lla;
		logic seen;
		seen = 1'h0;
		r.load_lookahead_instruction = 1'h1;
		r.stage3_program_address = 24'h000600;
		r.displacement = 12'h003;
		r.active_levels = 3'h1;
		redirect(1'h0, 24'h0);
		take(24'h000348);
		take(24'h000349);
		for (int n = 0; n < 60 && !seen; n++) begin
			seen = mreq.mem_req === 1'h1 && mreq.mem_octet_addr === 21'h0000c0;
			@(negedge clock);
		end
		chk(seen, 1'h1);
		$display("look-ahead transfer done");
	endtask
	task automatic t_stop;
		s3.stop = 1'h1;
		repeat (12) @(negedge clock);
		chk(mreq.mem_req, 1'h0);
		repeat (4) @(negedge clock);
		chk(mreq.mem_req, 1'h0);
		s3.stop = 1'h0;
		$display("stop done");
	endtask
	initial begin
		rst = 1'h1;
		s3 = '0;
		r = '0;
		ir_take = 1'h0;
		hold = 1'h1;
		repeat (16) @(negedge clock);
		rst = 1'h0;
		chk(mreq.mem_req, 1'h0);
		chk(word_valid, 1'h0);
		chk(file_full, 2'h0);
		t_start;
		t_branch;
		t_hazard;
		t_inoct;
		t_lla;
		t_stop;
		print_verdict;
	end
endmodule
